// >>> pkg/table_xfer_pkg.sv
// Constants, types and the overview for the table-transfer execution logic
// Overview of operation
// RL1: Split opcode copies source bits 7..4 to second register, 3..0 to accumulator, one cycle.
// RL2: Table lookup decodes on upper opcode bits 0010; low six bits give the page.
// RL3: Lookup start increments stack index, pushes PC, loads page field with immediate page.
// RL4: In-page address is data-pointer bits 2..0 above accumulator bits 3..0.
// RL5: Fetched word bits 7..4 load second register, bits 3..0 load accumulator.
// RL6: With transfer flag set, word bits 9..8 go to data pointer 1..0, bit 2 cleared.
// RL7: After the fetch, PC is popped from the stack entry, then stack index decrements.
// RL8: Lookup uses one return stack level temporarily; one free level is needed.
// RL9: Execution resumes after the lookup; carry and skip are never touched.
package table_xfer_pkg;
    localparam int        WORD_W        = 10;
    localparam int        PAGE_W        = 7;
    localparam int        INPAGE_W      = 7;
    localparam int        PC_W          = PAGE_W + INPAGE_W;
    localparam int        NIB_W         = 4;
    localparam logic [9:0] OP_SPLIT     = 10'h02A;
    localparam logic [3:0] OP_TABLE_HI  = 4'h2;
    localparam int        TABLE_CYCLES  = 3;
    localparam int        STACK_DEPTH   = 8;
    localparam int        SI_W          = $clog2(STACK_DEPTH);

    typedef struct packed {
        logic [NIB_W-1:0] acc;
        logic [NIB_W-1:0] breg;
        logic [2:0]       dptr;
    } regs_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_RESTORE
    } exec_state_t;
endpackage : table_xfer_pkg

// >>> verilog/return_stack_mem.sv
// Return-address stack storage, indexed by the stack index
`timescale 1ns/100ps
`default_nettype none
module return_stack_mem
    import table_xfer_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW    = SI_W
) (
    input  wire logic            clk_in,
    input  wire logic            resetn_in,
    input  wire logic            wr_in,
    input  wire logic [AW-1:0]   idx_in,
    input  wire logic [PC_W-1:0] wdata_in,
    output logic      [PC_W-1:0] rdata_out
);
    logic [PC_W-1:0] entry [DEPTH];

    assign rdata_out = entry[idx_in];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= '0;
            end
        end else if (wr_in) begin
            entry[idx_in] <= wdata_in;
        end
    end
endmodule : return_stack_mem
`default_nettype wire

// >>> verilog/table_opcode_decode.sv
// Opcode decoder for the split and table-lookup instructions
`timescale 1ns/100ps
`default_nettype none
module table_opcode_decode
    import table_xfer_pkg::*;
(
    input  wire logic [WORD_W-1:0] opcode_in,
    output logic                   is_split_out,
    output logic                   is_table_out,
    output logic [5:0]             page_out
);
    assign is_split_out = (opcode_in == OP_SPLIT); // RL1
    assign is_table_out = (opcode_in[9:6] == OP_TABLE_HI); // RL2
    assign page_out     = opcode_in[5:0]; // RL2
endmodule : table_opcode_decode
`default_nettype wire

// >>> verilog/table_transfer_instr_exec.sv
// Execution of the split transfer and the three-cycle table lookup
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module table_transfer_instr_exec
    import table_xfer_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  instr_valid_in,
    input  wire logic [WORD_W-1:0]     opcode_in,
    input  wire logic [PC_W-1:0]       pc_in,
    input  wire logic [7:0]            src_reg_in,
    input  wire logic [NIB_W-1:0]      acc_in,
    input  wire logic [2:0]            dptr_in,
    input  wire logic                  upper_bits_transfer_flag_in,
    input  wire logic [WORD_W-1:0]     rom_data_in,
    output logic      [PC_W-1:0]       rom_addr_out,
    output logic                       rom_rd_out,
    output regs_t                      regs_out,
    output logic                       acc_we_out,
    output logic                       breg_we_out,
    output logic                       dptr_we_out,
    output logic                       busy_out,
    output logic                       pc_load_out,
    output logic      [PC_W-1:0]       pc_value_out,
    output logic      [SI_W-1:0]       stack_index_out,
    output logic                       stack_overflow_out
);
    exec_state_t         state;
    exec_state_t         next_state;
    logic [SI_W-1:0]     stack_index;
    logic                is_split;
    logic                is_table;
    logic [5:0]          page;
    logic [PC_W-1:0]     popped_pc;
    logic [SI_W-1:0]     push_index;
    logic                start_split;
    logic                start_table;
    logic                push_wr;
    logic [PC_W-1:0]     lookup_addr;

    table_opcode_decode u_decode (
        .opcode_in    (opcode_in),
        .is_split_out (is_split),
        .is_table_out (is_table),
        .page_out     (page)
    );

    assign start_split = instr_valid_in && (state == ST_IDLE) && is_split;
    assign start_table = instr_valid_in && (state == ST_IDLE) && is_table;
    assign push_index  = SI_W'(stack_index + 1'b1); // RL3
    assign push_wr     = start_table; // RL3 RL8

    // Page field from immediate, in-page field from pointer and accumulator
    assign lookup_addr = {PAGE_W'(page), dptr_in, acc_in}; // RL3 RL4

    return_stack_mem #(
        .DEPTH (DEPTH),
        .AW    (SI_W)
    ) u_stack (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .wr_in     (push_wr),
        .idx_in    (start_table ? push_index : stack_index),
        .wdata_in  (pc_in), // RL3
        .rdata_out (popped_pc)
    );

    always_comb begin
        case (state)
            ST_IDLE:    next_state = start_table ? ST_FETCH : ST_IDLE;
            ST_FETCH:   next_state = ST_RESTORE;
            ST_RESTORE: next_state = ST_IDLE;
            default:    next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state       <= ST_IDLE;
            stack_index <= '0;
        end else begin
            state <= next_state;
            if (start_table) begin
                stack_index <= push_index; // RL3
            end else if (state == ST_RESTORE) begin
                stack_index <= SI_W'(stack_index - 1'b1); // RL7
            end
        end
    end

    // Stack use indicator: a push made while the index is at the last level wraps to level 0
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stack_overflow_out <= 1'b0;
        end else begin
            stack_overflow_out <= start_table && (stack_index == SI_W'(DEPTH - 1)); // RL8
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rom_addr_out <= '0;
            rom_rd_out   <= 1'b0;
        end else begin
            rom_rd_out <= start_table;
            if (start_table) begin
                rom_addr_out <= lookup_addr; // RL4
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            regs_out    <= '0;
            acc_we_out  <= 1'b0;
            breg_we_out <= 1'b0;
            dptr_we_out <= 1'b0;
        end else begin
            acc_we_out  <= start_split || (state == ST_FETCH);
            breg_we_out <= start_split || (state == ST_FETCH);
            dptr_we_out <= (state == ST_FETCH) && upper_bits_transfer_flag_in; // RL6
            if (start_split) begin
                regs_out.breg <= src_reg_in[7:4]; // RL1
                regs_out.acc  <= src_reg_in[3:0]; // RL1
            end else if (state == ST_FETCH) begin
                regs_out.breg <= rom_data_in[7:4]; // RL5
                regs_out.acc  <= rom_data_in[3:0]; // RL5
                if (upper_bits_transfer_flag_in) begin
                    regs_out.dptr <= {1'b0, rom_data_in[9:8]}; // RL6
                end
            end
        end
    end

    // Program counter is handed back from the stack; carry and skip are untouched
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_out     <= 1'b0;
            pc_load_out  <= 1'b0;
            pc_value_out <= '0;
        end else begin
            busy_out    <= (next_state != ST_IDLE);
            pc_load_out <= (state == ST_RESTORE); // RL7 RL9
            if (state == ST_RESTORE) begin
                pc_value_out <= popped_pc; // RL7 RL9
            end
        end
    end

    assign stack_index_out = stack_index;
endmodule : table_transfer_instr_exec
`default_nettype wire

// >>> verification/table_transfer_instr_exec_assertions.sv
// Assertion checker for the table-transfer execution block
`timescale 1ns/100ps
`default_nettype none
module table_transfer_instr_exec_checker
    import table_xfer_pkg::*;
#(parameter int DEPTH = STACK_DEPTH) (
    input wire logic              clk_in,
    input wire logic              resetn_in,
    input wire logic              instr_valid_in,
    input wire logic [WORD_W-1:0] opcode_in,
    input wire logic [PC_W-1:0]   pc_in,
    input wire logic [7:0]        src_reg_in,
    input wire logic [NIB_W-1:0]  acc_in,
    input wire logic [2:0]        dptr_in,
    input wire logic              upper_bits_transfer_flag_in,
    input wire logic [WORD_W-1:0] rom_data_in,
    input wire logic [PC_W-1:0]   rom_addr_out,
    input wire logic              rom_rd_out,
    input wire regs_t             regs_out,
    input wire logic              acc_we_out,
    input wire logic              dptr_we_out,
    input wire logic              busy_out,
    input wire logic              pc_load_out,
    input wire logic [PC_W-1:0]   pc_value_out,
    input wire logic [SI_W-1:0]   stack_index_out,
    input wire logic              breg_we_out,
    input wire logic              stack_overflow_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire take = instr_valid_in && !busy_out;
    wire tstart = take && opcode_in[9:6] == OP_TABLE_HI;
    wire sstart = take && opcode_in == OP_SPLIT;
    a_split_regs: assert property (sstart |=> acc_we_out && regs_out.acc == $past(src_reg_in[3:0])
        && regs_out.breg == $past(src_reg_in[7:4])) else $error("split result wrong");
    a_table_addr: assert property (tstart |=> rom_rd_out && rom_addr_out ==
        {1'b0, $past(opcode_in[5:0]), $past(dptr_in), $past(acc_in)}) else $error("rom address wrong");
    a_table_span: assert property (tstart |=> busy_out [*2] ##1 (!busy_out && pc_load_out))
        else $error("lookup length wrong");
    a_return_pc: assert property (tstart |-> ##3 pc_value_out == $past(pc_in, 3))
        else $error("restored pc wrong");
    a_word_regs: assert property (rom_rd_out |=> acc_we_out && regs_out.acc == $past(rom_data_in[3:0])
        && regs_out.breg == $past(rom_data_in[7:4])) else $error("word to registers wrong");
    a_flag_dptr: assert property (rom_rd_out && upper_bits_transfer_flag_in |=> dptr_we_out
        && regs_out.dptr == {1'b0, $past(rom_data_in[9:8])}) else $error("pointer load wrong");
    a_flag_off: assert property (rom_rd_out && !upper_bits_transfer_flag_in |=> !dptr_we_out)
        else $error("pointer written with flag clear");
    a_stack_level: assert property (tstart |=> stack_index_out == $past(stack_index_out) + 1'b1
        ##2 stack_index_out == $past(stack_index_out, 3)) else $error("stack index unbalanced");
    a_we_pulses: assert property (sstart || rom_rd_out |=> acc_we_out && breg_we_out)
        else $error("register write pulse missing");
    a_no_stray_we: assert property (!sstart && !rom_rd_out |=> !acc_we_out && !breg_we_out)
        else $error("register written without a taken instruction");
    a_overflow_flag: assert property (stack_overflow_out ==
        $past(tstart && stack_index_out == SI_W'(DEPTH - 1))) else $error("overflow flag wrong");
    cover property (sstart);
    cover property (rom_rd_out && upper_bits_transfer_flag_in);
    cover property (rom_rd_out && !upper_bits_transfer_flag_in);
    cover property (pc_load_out);
endmodule : table_transfer_instr_exec_checker
bind table_transfer_instr_exec table_transfer_instr_exec_checker #(.DEPTH(DEPTH)) chk_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in),
    .opcode_in(opcode_in), .pc_in(pc_in), .src_reg_in(src_reg_in), .acc_in(acc_in),
    .dptr_in(dptr_in), .upper_bits_transfer_flag_in(upper_bits_transfer_flag_in),
    .rom_data_in(rom_data_in), .rom_addr_out(rom_addr_out), .rom_rd_out(rom_rd_out),
    .regs_out(regs_out), .acc_we_out(acc_we_out), .dptr_we_out(dptr_we_out),
    .busy_out(busy_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .stack_index_out(stack_index_out), .breg_we_out(breg_we_out),
    .stack_overflow_out(stack_overflow_out));
`default_nettype wire

// >>> verification/tb_table_transfer_instr_exec.sv
// Self-checking bench for the table-transfer execution block
`timescale 1ns/100ps
`default_nettype none
module tb_table_transfer_instr_exec
    import table_xfer_pkg::*;
;
    logic              clk_in, resetn_in, instr_valid_in, upper_bits_transfer_flag_in;
    logic [WORD_W-1:0] opcode_in, rom_data_in;
    logic [PC_W-1:0]   pc_in, rom_addr_out, pc_value_out;
    logic [7:0]        src_reg_in;
    logic [NIB_W-1:0]  acc_in;
    logic [2:0]        dptr_in, exp_dptr;
    logic [SI_W-1:0]   stack_index_out;
    logic              rom_rd_out, acc_we_out, breg_we_out, dptr_we_out;
    logic              busy_out, pc_load_out, stack_overflow_out;
    regs_t             regs_out;
    int                failures, checks;
    table_transfer_instr_exec dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .instr_valid_in(instr_valid_in), .opcode_in(opcode_in), .pc_in(pc_in),
        .src_reg_in(src_reg_in), .acc_in(acc_in), .dptr_in(dptr_in),
        .upper_bits_transfer_flag_in(upper_bits_transfer_flag_in), .rom_data_in(rom_data_in),
        .rom_addr_out(rom_addr_out), .rom_rd_out(rom_rd_out), .regs_out(regs_out),
        .acc_we_out(acc_we_out), .breg_we_out(breg_we_out), .dptr_we_out(dptr_we_out),
        .busy_out(busy_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
        .stack_index_out(stack_index_out), .stack_overflow_out(stack_overflow_out));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic split(input logic [7:0] s);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        opcode_in <= OP_SPLIT;
        src_reg_in <= s;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({3'h0, acc_we_out, breg_we_out, regs_out}, {3'h0, 2'h3, s[3:0], s[7:4], exp_dptr});
    endtask : split
    task automatic ignored(input logic [WORD_W-1:0] op);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        opcode_in <= op;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({13'h0, acc_we_out, rom_rd_out, busy_out}, 16'h0000);
    endtask : ignored
    task automatic lookup(input logic [5:0] pg, input logic [3:0] a, input logic [2:0] d,
                          input logic f, input logic [WORD_W-1:0] w);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        opcode_in <= {OP_TABLE_HI, pg};
        acc_in <= a;
        dptr_in <= d;
        pc_in <= {pg, 8'h5A};
        upper_bits_transfer_flag_in <= f;
        @(posedge clk_in);
        opcode_in <= OP_SPLIT;
        rom_data_in <= w;
        #1;
        chk({1'h0, rom_rd_out, rom_addr_out}, {2'h1, 1'h0, pg, d, a});
        chk({12'h0, stack_overflow_out, stack_index_out}, 16'h0001);
        if (f) exp_dptr = {1'b0, w[9:8]};
        @(posedge clk_in);
        #1;
        chk({3'h0, acc_we_out, dptr_we_out, regs_out}, {3'h0, 1'h1, f, w[3:0], w[7:4], exp_dptr});
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({1'h0, pc_load_out, pc_value_out}, {2'h1, pg, 8'h5A});
        chk({12'h0, acc_we_out, stack_index_out}, 16'h0000);
    endtask : lookup
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (500) @(posedge clk_in);
        failures++;
        stop_test();
    end
    initial begin
        {resetn_in, instr_valid_in, upper_bits_transfer_flag_in} = 3'h0;
        {opcode_in, rom_data_in, pc_in, src_reg_in, acc_in, dptr_in} = '0;
        exp_dptr = 3'h0;
        failures = 0;
        checks = 0;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        chk({6'h0, rom_rd_out, acc_we_out, breg_we_out, dptr_we_out, busy_out, pc_load_out,
             stack_overflow_out, stack_index_out}, 16'h0000);
        chk({5'h0, regs_out}, 16'h0000);
        chk({2'h0, rom_addr_out}, 16'h0000);
        chk({2'h0, pc_value_out}, 16'h0000);
        split(8'hA5);
        ignored(10'h3FF);
        ignored(10'h02B);
        split(8'h3C);
        lookup(6'h00, 4'hF, 3'h7, 1'b1, 10'h3FF);
        lookup(6'h3F, 4'h0, 3'h5, 1'b0, 10'h2A5);
        lookup(6'h15, 4'h9, 3'h2, 1'b1, 10'h15A);
        split(8'h0F);
        stop_test();
    end
endmodule : tb_table_transfer_instr_exec
`default_nettype wire
